// ===== hdl/cantmo_defines.svh
// timing and sizing constants of the transceiver mode and timeout block
`ifndef CANTMO_DEFINES_SVH
`define CANTMO_DEFINES_SVH

`define CANTMO_CLK_MHZ       125
// nominal dominant timeout in microseconds
`define CANTMO_TIMEOUT_US    2000
`define CANTMO_TIMEOUT_CYC   (`CANTMO_TIMEOUT_US * `CANTMO_CLK_MHZ)
// transmit enable time after power-up or shutdown, microseconds
`define CANTMO_TXEN_US       40
`define CANTMO_TXEN_CYC      (`CANTMO_TXEN_US * `CANTMO_CLK_MHZ)
`define CANTMO_CNT_W         24
`define CANTMO_BUF_DEPTH     2

`endif

// ===== hdl/cantmo_pkg.sv
// types of the transceiver mode and timeout block
package cantmo_pkg;
	typedef enum logic [1:0]
	{
		CANTMO_SHUTDOWN  = 2'b00,
		CANTMO_RECESSIVE = 2'b01,
		CANTMO_DOMINANT  = 2'b10,
		CANTMO_TIMED_OUT = 2'b11
	} cantmo_state_type;
endpackage : cantmo_pkg

// ===== hdl/cantmo_buf.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module cantmo_buf
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// fill side
	input  wire logic in_valid,
	output logic      in_ready,
	input  wire logic in_data,
	// drain side
	output logic      out_valid,
	input  wire logic out_ready,
	output logic      out_data
);
	logic [1:0] mem;
	logic [1:0] count;
	logic       rd_ptr;
	logic       wr_ptr;
	wire        push = in_valid && in_ready;
	wire        pop  = out_valid && out_ready;

	assign in_ready  = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data  = mem[rd_ptr];

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mem    <= 2'h3;
			count  <= 2'h0;
			rd_ptr <= 1'b0;
			wr_ptr <= 1'b0;
		end
		else
		begin
			if (push)
			begin
				mem[wr_ptr] <= in_data;
				wr_ptr      <= ~wr_ptr;
			end
			if (pop)
				rd_ptr <= ~rd_ptr;
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : cantmo_buf
`default_nettype wire

// ===== hdl/cantmo_top.sv
// transceiver mode selection and dominant timeout logic
// Summary of operation
// - low shutdown and low input drive dominant
// - high input leaves bus recessive, drivers released
// - shutdown high releases drivers and receive output
// - dominant timeout timer, nominally two milliseconds
// - timeout forces recessive while input stays low
// - input high clears the timeout timer
// - after timeout, dominant needs high then low
// - receive output follows bus, input pulled high
// - power-up starts timed out, needs high then low after enable time
// - over-temperature forces recessive, receiver keeps working
`timescale 1ns/1ps
`default_nettype none
`include "cantmo_defines.svh"
module cantmo_top
	import cantmo_pkg::*;
#(
	parameter int TIMEOUT_CYC = `CANTMO_TIMEOUT_CYC,
	parameter int TXEN_CYC    = `CANTMO_TXEN_CYC
)
(
	// clock and reset (reset stands for supply undervoltage)
	input  wire logic core_clk,
	input  wire logic rst,
	// controller side pins
	input  wire logic transmit_data_in,
	input  wire logic transmit_data_in_oe_n,
	input  wire logic shutdown_slew_ctrl,
	output logic      receive_data_out,
	output logic      receive_data_out_oe_n,
	// bus side
	input  wire logic bus_dominant_in,
	input  wire logic over_temp,
	output logic      canh_drive,
	output logic      canh_oe_n,
	output logic      canl_drive,
	output logic      canl_oe_n,
	output logic      rx_load_connect,
	// status
	output logic      tx_timed_out
);
	localparam logic [`CANTMO_CNT_W-1:0] TO_LAST =
		`CANTMO_CNT_W'(TIMEOUT_CYC - 1);
	localparam logic [`CANTMO_CNT_W-1:0] EN_LAST =
		`CANTMO_CNT_W'(TXEN_CYC - 1);

	// ******************************************************
	// pin synchronisers
	// ******************************************************
	logic [2:0] txd_sync;
	logic [2:0] shdn_sync;
	logic [2:0] bus_sync;
	logic [2:0] temp_sync;
	logic       txd_q;
	logic       shdn_q;
	logic       bus_q;
	logic       temp_q;

	// an undriven transmit input reads high
	wire txd_pin = transmit_data_in_oe_n ? 1'b1 : transmit_data_in;

	function automatic logic settle(input logic [2:0] s, input logic q);
		settle = (s[1] == s[2]) ? s[2] : q;
	endfunction : settle

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			txd_sync  <= 3'h7;
			shdn_sync <= 3'h7;
			bus_sync  <= 3'h0;
			temp_sync <= 3'h0;
			txd_q     <= 1'b1;
			shdn_q    <= 1'b1;
			bus_q     <= 1'b0;
			temp_q    <= 1'b0;
		end
		else
		begin
			txd_sync  <= {txd_sync[1:0], txd_pin};
			shdn_sync <= {shdn_sync[1:0], shutdown_slew_ctrl};
			bus_sync  <= {bus_sync[1:0], bus_dominant_in};
			temp_sync <= {temp_sync[1:0], over_temp};
			txd_q     <= settle(txd_sync, txd_q);
			shdn_q    <= settle(shdn_sync, shdn_q);
			bus_q     <= settle(bus_sync, bus_q);
			temp_q    <= settle(temp_sync, temp_q);
		end
	end

	// ******************************************************
	// transmit data buffer
	// ******************************************************
	logic buf_in_ready;
	logic buf_valid;
	logic buf_data;
	logic txd_prev;
	wire  txd_change = (txd_q != txd_prev);
	wire  tx_word    = buf_valid ? buf_data : txd_prev;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			txd_prev <= 1'b1;
		else if (buf_in_ready)
			txd_prev <= txd_q;
	end

	cantmo_buf u_buf
	(
		.core_clk  (core_clk),
		.rst       (rst),
		.in_valid  (txd_change),
		.in_ready  (buf_in_ready),
		.in_data   (txd_q),
		.out_valid (buf_valid),
		.out_ready (1'b1),
		.out_data  (buf_data)
	);

	// ******************************************************
	// mode state machine and timers
	// ******************************************************
	cantmo_state_type                state;
	cantmo_state_type                next_state;
	logic [`CANTMO_CNT_W-1:0]        to_cnt;
	logic [`CANTMO_CNT_W-1:0]        en_cnt;
	logic                            tx_level;
	logic                            enabled;

	wire to_expired = (to_cnt == TO_LAST);
	wire en_done    = (en_cnt == EN_LAST);
	wire fall       = tx_level && !tx_word;

	always_comb
	begin
		next_state = state;
		unique case (state)
			CANTMO_SHUTDOWN:
				if (!shdn_q)
					next_state = CANTMO_TIMED_OUT;
			CANTMO_RECESSIVE:
				if (!tx_word && !temp_q)
					next_state = CANTMO_DOMINANT;
			// expiry wins over heat so a stuck low input stays held off
			CANTMO_DOMINANT:
				if (tx_word)
					next_state = CANTMO_RECESSIVE;
				else if (to_expired)
					next_state = CANTMO_TIMED_OUT;
				else if (temp_q)
					next_state = CANTMO_RECESSIVE;
			CANTMO_TIMED_OUT:
				if (fall && enabled && !temp_q)
					next_state = CANTMO_DOMINANT;
		endcase
		if (shdn_q)
			next_state = CANTMO_SHUTDOWN;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state    <= CANTMO_SHUTDOWN;
			to_cnt   <= '0;
			en_cnt   <= '0;
			enabled  <= 1'b0;
			tx_level <= 1'b1;
		end
		else
		begin
			state    <= next_state;
			tx_level <= tx_word;
			// timer counts dominant time, cleared by high input
			if (next_state != CANTMO_DOMINANT)
				to_cnt <= '0;
			else if (state == CANTMO_DOMINANT && !to_expired)
				to_cnt <= to_cnt + 1'b1;
			if (shdn_q)
			begin
				en_cnt  <= '0;
				enabled <= 1'b0;
			end
			else if (!en_done)
				en_cnt <= en_cnt + 1'b1;
			else
				enabled <= 1'b1;
		end
	end

	// ******************************************************
	// registered outputs
	// ******************************************************
	wire dom_next  = (next_state == CANTMO_DOMINANT);
	wire shdn_next = (next_state == CANTMO_SHUTDOWN);

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			canh_drive            <= 1'b0;
			canl_drive            <= 1'b0;
			canh_oe_n             <= 1'b1;
			canl_oe_n             <= 1'b1;
			receive_data_out      <= 1'b1;
			receive_data_out_oe_n <= 1'b1;
			rx_load_connect       <= 1'b0;
			tx_timed_out          <= 1'b1;
		end
		else
		begin
			canh_drive            <= dom_next;
			canl_drive            <= 1'b0;
			canh_oe_n             <= !dom_next;
			canl_oe_n             <= !dom_next;
			receive_data_out      <= !bus_q;
			receive_data_out_oe_n <= shdn_next;
			rx_load_connect       <= !shdn_next;
			tx_timed_out          <= (next_state == CANTMO_TIMED_OUT);
		end
	end

	// ******************************************************
	// assertions
	// ******************************************************
	sequence dom_held;
		!canh_oe_n && !shdn_q;
	endsequence

	AST_SHDN_RELEASE: assert property (@(posedge core_clk) disable iff (rst)
		shdn_q |=> canh_oe_n && canl_oe_n && receive_data_out_oe_n)
		else $error("shutdown left a driver enabled");
	AST_DOM_PINS: assert property (@(posedge core_clk) disable iff (rst)
		!canh_oe_n |-> canh_drive && !canl_oe_n && !canl_drive)
		else $error("dominant drive inconsistent");
	AST_REC_HIGH: assert property (@(posedge core_clk) disable iff (rst)
		(state == CANTMO_DOMINANT && tx_word && !shdn_q) |=> canh_oe_n)
		else $error("high input did not release bus");
	AST_TIMEOUT: assert property (@(posedge core_clk) disable iff (rst)
		(state == CANTMO_DOMINANT && to_expired && !tx_word && !shdn_q)
		|=> canh_oe_n && tx_timed_out)
		else $error("timeout did not force recessive");
	AST_TIMER_BOUND: assert property (@(posedge core_clk) disable iff (rst)
		to_cnt <= TO_LAST)
		else $error("timeout counter ran past terminal count");
	AST_TIMER_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
		(state == CANTMO_DOMINANT && tx_word) |=> to_cnt == '0)
		else $error("high input did not clear timer");
	AST_STAY_TO: assert property (@(posedge core_clk) disable iff (rst)
		(state == CANTMO_TIMED_OUT && !fall) |=> state != CANTMO_DOMINANT)
		else $error("redominant without a falling input");
	AST_TEMP: assert property (@(posedge core_clk) disable iff (rst)
		dom_held ##0 temp_q |=> canh_oe_n)
		else $error("over temperature kept dominant drive");
	AST_RXD: assert property (@(posedge core_clk) disable iff (rst)
		!shdn_q ##1 !shdn_q |-> receive_data_out == !$past(bus_q))
		else $error("receive output does not follow bus");
	AST_WAKE: assert property (@(posedge core_clk) disable iff (rst)
		$fell(shdn_q) |=> state == CANTMO_TIMED_OUT)
		else $error("wake did not enter timed out state");
endmodule : cantmo_top
`default_nettype wire

// ===== verification/cantmo_ctrl_model.sv
// controller-side model driving the transmit and mode pins
`timescale 1ns/1ps
`default_nettype none
module cantmo_ctrl_model
(
	// clock
	input  wire logic core_clk,
	// bench requests
	input  wire logic req_txd,
	input  wire logic req_open,
	input  wire logic req_shdn,
	// controller pins
	output logic      transmit_data_in,
	output logic      transmit_data_in_oe_n,
	output logic      shutdown_slew_ctrl
);
	// pins follow the requests at once; the bench moves them on the
	// falling edge, away from the sampling edge
	// dominant runs last only as long as the bench asks
	assign transmit_data_in_oe_n = req_open;
	// a released pin reads high through the pull-up
	assign transmit_data_in      = req_open | req_txd;
	// driven firmly from the shutdown request, high only while the bench asks for shutdown
	assign shutdown_slew_ctrl    = req_shdn;
endmodule : cantmo_ctrl_model
`default_nettype wire

// ===== verification/cantmo_top_tb_top.sv
// testbench of the transceiver mode and timeout block
`timescale 1ns/1ps
`default_nettype none
module cantmo_top_tb_top
	import cantmo_pkg::*;
;
	localparam int TO = 50;
	localparam int EN = 20;
	logic core_clk = 1'b0;
	logic rst      = 1'b1;
	logic txd      = 1'b0;
	logic open_pin = 1'b0;
	logic shdn     = 1'b0;
	logic ext_dom  = 1'b0;
	logic over_temp = 1'b0;
	logic tdi, tdi_oe_n, ssc, rxd, rxd_oe_n, canh_d, canh_oe_n;
	logic canl_d, canl_oe_n, rx_load, timed_out;
	wire logic bus_dom = ~canh_oe_n | ext_dom;
	int failures = 0;
	int num_checks = 0;

	cantmo_ctrl_model u_cantmo_ctrl_model (.core_clk(core_clk),
		.req_txd(txd), .req_open(open_pin), .req_shdn(shdn),
		.transmit_data_in(tdi), .transmit_data_in_oe_n(tdi_oe_n),
		.shutdown_slew_ctrl(ssc));
	cantmo_top #(.TIMEOUT_CYC(TO), .TXEN_CYC(EN)) u_cantmo_top (
		.core_clk(core_clk), .rst(rst), .transmit_data_in(tdi),
		.transmit_data_in_oe_n(tdi_oe_n), .shutdown_slew_ctrl(ssc),
		.receive_data_out(rxd), .receive_data_out_oe_n(rxd_oe_n),
		.bus_dominant_in(bus_dom), .over_temp(over_temp),
		.canh_drive(canh_d), .canh_oe_n(canh_oe_n), .canl_drive(canl_d),
		.canl_oe_n(canl_oe_n), .rx_load_connect(rx_load),
		.tx_timed_out(timed_out));

	initial
	begin
		forever #4 core_clk = ~core_clk;
	end

	// ********
	// checks
	// ********
	task automatic chk(input string name, input logic seen, input logic exp);
		num_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %b seen %b", name, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	task automatic dom(input logic exp);
		chk("canh_oe_n", canh_oe_n, ~exp);
		chk("canl_oe_n", canl_oe_n, ~exp);
		chk("receive_data_out", rxd, ~exp);
	endtask : dom

	task automatic fall();
		txd = 1'b1;
		cyc(6);
		txd = 1'b0;
		cyc(12);
	endtask : fall

	task automatic final_report();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	// ***********
	// scenarios
	// ***********
	task automatic t_power_up();
		cyc(2);
		dom(1'b0);
		chk("rx_load_connect", rx_load, 1'b0);
		chk("tx_timed_out", timed_out, 1'b1);
		cyc(1);
		rst = 1'b0;
		cyc(EN + 15);
		dom(1'b0);
		chk("rx_load_connect", rx_load, 1'b1);
		open_pin = 1'b1;
		cyc(6);
		open_pin = 1'b0;
		cyc(12);
		dom(1'b1);
		chk("canh_drive", canh_d, 1'b1);
		chk("canl_drive", canl_d, 1'b0);
	endtask : t_power_up

	task automatic t_timeout();
		// dominant began six and a half cycles before this task
		cyc(TO - 8);
		dom(1'b1);
		cyc(2);
		chk("canh_oe_n", canh_oe_n, 1'b1);
		chk("tx_timed_out", timed_out, 1'b1);
		cyc(12);
		dom(1'b0);
		txd = 1'b1;
		cyc(10);
		dom(1'b0);
		chk("tx_timed_out", timed_out, 1'b1);
		txd = 1'b0;
		cyc(12);
		dom(1'b1);
	endtask : t_timeout

	task automatic t_clear();
		cyc(20);
		txd = 1'b1;
		cyc(12);
		dom(1'b0);
		txd = 1'b0;
		cyc(TO - 5);
		dom(1'b1);
	endtask : t_clear

	task automatic t_over_temp();
		over_temp = 1'b1;
		ext_dom = 1'b1;
		cyc(10);
		chk("canh_oe_n", canh_oe_n, 1'b1);
		chk("receive_data_out", rxd, 1'b0);
		// the receiver keeps following the bus while hot
		ext_dom = 1'b0;
		cyc(12);
		chk("receive_data_out", rxd, 1'b1);
		fall();
		chk("canh_oe_n", canh_oe_n, 1'b1);
		txd = 1'b1;
		cyc(6);
		over_temp = 1'b0;
		fall();
		dom(1'b1);
	endtask : t_over_temp

	task automatic t_shutdown();
		shdn = 1'b1;
		fall();
		chk("canh_oe_n", canh_oe_n, 1'b1);
		chk("canl_oe_n", canl_oe_n, 1'b1);
		chk("receive_data_out_oe_n", rxd_oe_n, 1'b1);
		chk("rx_load_connect", rx_load, 1'b0);
		shdn = 1'b0;
		// a fall inside the enable time is ignored
		fall();
		chk("canh_oe_n", canh_oe_n, 1'b1);
		chk("tx_timed_out", timed_out, 1'b1);
		cyc(EN);
		fall();
		dom(1'b1);
	endtask : t_shutdown

	// ******
	// main
	// ******
	initial
	begin
		t_power_up();
		t_timeout();
		t_clear();
		t_over_temp();
		t_shutdown();
		final_report();
	end

	initial
	begin
		cyc(3000);
		failures++;
		final_report();
	end
endmodule : cantmo_top_tb_top
`default_nettype wire
